// file: rtl/srp_dev.sv
// adapter end: link detect, reset pin, pairing sequence, response sender
// ----------------------------------------
// Summary of operation
// [R1] link_up_n low while radio link exists
// [R2] reset pin low 1 s restores defaults
// [R3] host: unit one reset, pair low 2 s
// [R4] host: unit two low, high, low, 2 s each
// [R5] pairing lows step modes, second makes master
// [R6] host allows 10 s for connection
// [R7] no responses sent while pairing
// [R8] pairing swaps in pairing class value
// [R9] four responses: OK ERROR CONNECT DISCONNECT
// [R10] four operation modes supported; the code never enters wait_last_mode, so mode only takes three of them
// [R11] status standby, pending or connect
// [R12] CR 0x0D and LF 0x0A frame lines
// [R13] addresses hex, options digit, timeouts seconds
// [R14] txd/rts out, rxd/cts in, flow control
// [R15] 9600 8N1 hwfc default, applied on reset
// [R16] tick timer, debounced pin inputs
// ----------------------------------------
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "srp_cfg.svh"
module srp_dev #(
  parameter int unsigned TICK_CYC = `SRP_TICK_CYC
) (
  input wire logic sys_clk, // 10 MHz clock
  input wire logic reset_n, // async reset, low active
  srp_if.dev pins, // pins toward host
  input wire logic radio_link, // radio core reports link
  input wire logic soft_reset, // pulse: apply pending serial settings
  input wire logic [15:0] baud_div_new, // pending baud divisor
  input wire logic hwfc_new, // pending flow control enable
  input wire logic resp_req, // request to send a response
  input wire srp_pkg::srp_resp_t resp_kind, // response to send
  input wire logic rx_full, // user cannot take more serial data
  input wire logic [23:0] class_normal, // normal class value
  input wire logic [23:0] class_pairing, // class value used while pairing
  output logic rx_line, // registered rxd toward user
  output srp_pkg::srp_mode_t mode, // operation mode
  output srp_pkg::srp_status_t status, // operation status
  output logic master, // link master role
  output logic pairing, // pairing in progress
  output logic [23:0] device_class_value, // class value in use
  output logic factory_restore, // pulse: restore defaults
  output logic resp_busy // response being sent
);
  import srp_pkg::*;

  typedef struct packed {
    logic [23:0] tick_cnt;
    logic tick;
    logic [1:0] pin_raw;
    logic [1:0] pin_stable;
    logic [1:0][3:0] deb_cnt;
    logic [10:0] rst_cnt;
    logic restore;
    logic pair_prev;
    srp_mode_t mode;
    logic pairing;
    logic master;
    logic link;
    srp_status_t status;
    logic [23:0] cls;
    logic rx_line;
    logic rts_n;
    logic [15:0] baud_div;
    logic hwfc;
    logic tx_busy;
    srp_resp_t tx_kind;
    logic [3:0] tx_idx;
    logic [3:0] tx_bit;
    logic [9:0] tx_sh;
    logic [15:0] baud_cnt;
    logic txd;
  } srp_dev_state_t;

  srp_dev_state_t s;
  srp_dev_state_t next_s;

  // ----------------------------------------
  // response text
  // ----------------------------------------
  function automatic logic [3:0] text_len(input srp_resp_t k);
    case (k)
      srp_ok: text_len = 4'h2;
      srp_error: text_len = 4'h5;
      srp_connect_msg: text_len = 4'h7;
      default: text_len = 4'hA;
    endcase
  endfunction

  // every response is CR LF text CR LF
  function automatic logic [7:0] resp_byte(input srp_resp_t k, input logic [3:0] i);
    logic [79:0] txt;
    logic [3:0] n;
    logic [3:0] c;
    txt = 80'h0;
    n = text_len(k);
    c = 4'h0;
    case (k)
      srp_ok: txt = 80'(16'h4F4B);
      srp_error: txt = 80'(40'h4552524F52);
      srp_connect_msg: txt = 80'(56'h434F4E4E454354);
      default: txt = 80'h444953434F4E4E454354;
    endcase
    if (i == 4'h0 || i == n + 4'h2) begin
      resp_byte = `SRP_CR; // [R12]
    end else if (i == 4'h1 || i == n + 4'h3) begin
      resp_byte = `SRP_LF; // [R12]
    end else begin
      c = n + 4'h1 - i;
      resp_byte = txt[{c, 3'b000} +: 8];
    end
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic fall;
    logic [15:0] last_baud;
    fall = 1'b0;
    last_baud = 16'h0;
    next_s = s;
    next_s.tick = 1'b0;
    next_s.restore = 1'b0;
    // free running millisecond tick times every long interval
    if (s.tick_cnt == 24'(TICK_CYC - 1)) begin // [R16]
      next_s.tick_cnt = 24'h0;
      next_s.tick = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 24'h1;
    end
    next_s.pin_raw = {pins.pair_n, pins.rst_n};
    // a level counts only after holding for several ticks
    for (int i = 0; i < 2; i++) begin
      if (s.pin_raw[i] == s.pin_stable[i]) begin
        next_s.deb_cnt[i] = 4'h0;
      end else if (s.tick) begin
        if (s.deb_cnt[i] == 4'(`SRP_DEB_TICKS - 1)) begin // [R16]
          next_s.pin_stable[i] = s.pin_raw[i];
          next_s.deb_cnt[i] = 4'h0;
        end else begin
          next_s.deb_cnt[i] = s.deb_cnt[i] + 4'h1;
        end
      end
    end
    next_s.link = radio_link;
    next_s.rx_line = pins.rxd; // [R14]
    next_s.rts_n = rx_full; // [R14]
    if (soft_reset) begin
      next_s.baud_div = baud_div_new; // [R15]
      next_s.hwfc = hwfc_new; // [R15]
    end
    // pairing lows walk the mode ladder
    fall = s.pair_prev & ~s.pin_stable[1];
    next_s.pair_prev = s.pin_stable[1];
    if (fall) begin
      case (s.mode)
        cmd_wait_mode: begin
          next_s.mode = wait_any_mode; // [R5]
          next_s.pairing = 1'b1;
        end
        wait_any_mode: begin
          if (s.pairing) begin
            next_s.mode = connect_last_mode; // [R5]
            next_s.master = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (s.link && s.pairing) begin
      next_s.pairing = 1'b0;
    end
    // short pulses on the reset pin never reach the count
    if (s.pin_stable[0]) begin
      next_s.rst_cnt = 11'h0;
    end else if (s.tick && s.rst_cnt != 11'(`SRP_RESET_MS)) begin
      next_s.rst_cnt = s.rst_cnt + 11'h1;
      if (s.rst_cnt == 11'(`SRP_RESET_MS - 1)) begin
        next_s.restore = 1'b1; // [R2]
        next_s.mode = cmd_wait_mode; // [R5]
        next_s.pairing = 1'b0;
        next_s.master = 1'b0;
        next_s.baud_div = 16'(`SRP_BAUD_DIV); // [R15]
        next_s.hwfc = `SRP_HWFC_DEFAULT;
      end
    end
    if (s.link) begin
      next_s.status = srp_connect; // [R11]
    end else if (s.mode == cmd_wait_mode && !s.pairing) begin
      next_s.status = srp_standby; // [R11]
    end else begin
      next_s.status = srp_pending; // [R11]
    end
    next_s.cls = s.pairing ? class_pairing : class_normal; // [R8]
    // ----------------------------------------
    // response transmitter, 8N1
    // ----------------------------------------
    last_baud = s.baud_div - 16'h1;
    if (!s.tx_busy) begin
      // requests made while pairing are dropped, not queued
      if (resp_req && !s.pairing) begin // [R7]
        next_s.tx_busy = 1'b1;
        next_s.tx_kind = resp_kind; // [R9]
        next_s.tx_idx = 4'h0;
        next_s.tx_bit = 4'h0;
      end
    end else if (s.tx_bit == 4'h0) begin
      if (!s.hwfc || !pins.cts_n) begin // [R14]
        next_s.tx_sh = {1'b1, resp_byte(s.tx_kind, s.tx_idx), 1'b0};
        next_s.txd = 1'b0;
        next_s.tx_bit = 4'hA;
        next_s.baud_cnt = 16'h0;
      end
    end else if (s.baud_cnt == last_baud) begin
      next_s.baud_cnt = 16'h0;
      next_s.tx_bit = s.tx_bit - 4'h1;
      if (s.tx_bit != 4'h1) begin
        next_s.tx_sh = {1'b1, s.tx_sh[9:1]};
        next_s.txd = s.tx_sh[1];
      end else begin
        next_s.txd = 1'b1;
        next_s.tx_idx = s.tx_idx + 4'h1;
        if (s.tx_idx == text_len(s.tx_kind) + 4'h3) begin
          next_s.tx_busy = 1'b0;
        end
      end
    end else begin
      next_s.baud_cnt = s.baud_cnt + 16'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.pin_raw <= 2'b11;
      s.pin_stable <= 2'b11;
      s.pair_prev <= 1'b1;
      s.mode <= cmd_wait_mode; // [R10]
      s.status <= srp_standby;
      s.rts_n <= 1'b1;
      s.rx_line <= 1'b1;
      s.baud_div <= 16'(`SRP_BAUD_DIV); // [R15]
      s.hwfc <= `SRP_HWFC_DEFAULT;
      s.txd <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign pins.link_up_n = ~s.link; // [R1]
  assign pins.txd = s.txd; // [R14]
  assign pins.rts_n = s.rts_n;
  assign rx_line = s.rx_line;
  assign mode = s.mode;
  assign status = s.status;
  assign master = s.master;
  assign pairing = s.pairing;
  assign device_class_value = s.cls;
  assign factory_restore = s.restore;
  assign resp_busy = s.tx_busy;
endmodule

// file: rtl/srp_host.sv
// host end: drives reset and pairing pins, AHB-Lite register slave
`timescale 1ns/1ps
`include "srp_cfg.svh"
module srp_host #(
  parameter int unsigned TICK_CYC = `SRP_TICK_CYC
) (
  input wire logic sys_clk, // 10 MHz clock
  input wire logic reset_n, // async reset, low active
  srp_if.host pins, // pins toward adapter
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write
  input wire logic [2:0] hsize, // size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // always ready
  output logic [31:0] hrdata, // read data
  output logic hresp, // always OKAY
  output logic irq, // enabled event pending
  input wire logic user_txd, // serial data toward adapter
  input wire logic user_cts_n, // allow adapter to send
  output logic user_rxd, // serial data from adapter
  output logic user_rts_n // adapter ready
);
  import srp_pkg::*;

  typedef struct packed {
    logic [23:0] tick_cnt;
    logic tick;
    logic ap_valid;
    logic ap_write;
    logic [4:0] ap_addr;
    logic [31:0] rdata;
    srp_hseq_t seq;
    logic unit2;
    logic [13:0] seg_cnt;
    logic rst_n;
    logic pair_n;
    logic link_prev;
    logic [3:0] irq_stat;
    logic [3:0] irq_en;
  } srp_host_state_t;

  srp_host_state_t s;
  srp_host_state_t next_s;

  always_comb begin
    logic [3:0] ev;
    logic seg_end;
    logic link;
    ev = 4'h0;
    seg_end = 1'b0;
    link = ~pins.link_up_n;
    next_s = s;
    next_s.tick = 1'b0;
    if (s.tick_cnt == 24'(TICK_CYC - 1)) begin
      next_s.tick_cnt = 24'h0;
      next_s.tick = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 24'h1;
    end
    // ----------------------------------------
    // pin sequencer, one segment per state
    // ----------------------------------------
    if (s.tick && s.seq != hs_idle) begin
      next_s.seg_cnt = s.seg_cnt - 14'h1;
      seg_end = s.seg_cnt == 14'h1;
    end
    if (seg_end) begin
      case (s.seq)
        hs_rst: begin
          next_s.rst_n = 1'b1;
          next_s.seq = hs_gap;
          next_s.seg_cnt = 14'(`SRP_GAP_MS);
        end
        hs_gap: begin
          // plain factory reset ends here
          next_s.seq = (s.pair_n == 1'b0) ? hs_low1 : hs_idle;
          next_s.seg_cnt = 14'(`SRP_PAIR_MS); // [R3]
          ev[`SRP_IRQ_DONE_BIT] = s.pair_n;
        end
        hs_low1: begin
          next_s.pair_n = 1'b1;
          next_s.seq = s.unit2 ? hs_high : hs_wait;
          next_s.seg_cnt = s.unit2 ? 14'(`SRP_PAIR_MS) : 14'(`SRP_CONNECT_MS); // [R4]
        end
        hs_high: begin
          next_s.pair_n = 1'b0;
          next_s.seq = hs_low2;
          next_s.seg_cnt = 14'(`SRP_PAIR_MS); // [R4]
        end
        hs_low2: begin
          next_s.pair_n = 1'b1;
          next_s.seq = hs_wait;
          next_s.seg_cnt = 14'(`SRP_CONNECT_MS); // [R6]
        end
        hs_wait: begin
          next_s.seq = hs_idle;
          ev[`SRP_IRQ_TMO_BIT] = 1'b1; // [R6]
        end
        default: begin
          next_s.seq = hs_idle;
        end
      endcase
    end
    if (s.seq == hs_wait && link) begin
      next_s.seq = hs_idle;
      ev[`SRP_IRQ_DONE_BIT] = 1'b1;
    end
    next_s.link_prev = link;
    ev[`SRP_IRQ_UP_BIT] = link & ~s.link_prev;
    ev[`SRP_IRQ_DOWN_BIT] = ~link & s.link_prev;
    // ----------------------------------------
    // AHB-Lite slave, zero wait
    // ----------------------------------------
    next_s.ap_valid = hsel && htrans[1] && hready;
    if (hsel && htrans[1] && hready) begin
      next_s.ap_write = hwrite;
      next_s.ap_addr = haddr[4:0];
      case (haddr[4:0])
        `SRP_STAT_OFS: next_s.rdata = {28'h0, s.seq, link};
        `SRP_IRQ_STAT_OFS: next_s.rdata = {28'h0, s.irq_stat};
        `SRP_IRQ_EN_OFS: next_s.rdata = {28'h0, s.irq_en};
        default: next_s.rdata = 32'h0;
      endcase
    end
    if (s.ap_valid && s.ap_write) begin
      case (s.ap_addr)
        `SRP_CTRL_OFS: begin
          if (s.seq == hs_idle && hwdata[2:0] != 3'h0) begin
            next_s.seq = hs_rst; // [R3]
            next_s.rst_n = 1'b0; // [R2]
            next_s.seg_cnt = 14'(`SRP_HOST_RST_MS); // [R2]
            next_s.pair_n = ~(hwdata[`SRP_CTRL_PAIR1_BIT] | hwdata[`SRP_CTRL_PAIR2_BIT]);
            next_s.unit2 = hwdata[`SRP_CTRL_PAIR2_BIT];
          end
        end
        `SRP_IRQ_CLR_OFS: next_s.irq_stat = s.irq_stat & ~hwdata[3:0];
        `SRP_IRQ_EN_OFS: next_s.irq_en = hwdata[3:0];
        default: begin
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    next_s.irq_stat = next_s.irq_stat | ev;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.seq <= hs_idle;
      s.rst_n <= 1'b1;
      s.pair_n <= 1'b1;
      s.irq_en <= `SRP_IRQ_EN_RST;
    end else begin
      s <= next_s;
    end
  end

  assign pins.rst_n = s.rst_n;
  // pairing pin held high while reset pin is low
  assign pins.pair_n = s.pair_n | (s.seq == hs_rst) | (s.seq == hs_gap);
  assign pins.rxd = user_txd; // [R14]
  assign pins.cts_n = user_cts_n;
  assign user_rxd = pins.txd;
  assign user_rts_n = pins.rts_n;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign irq = |(s.irq_stat & s.irq_en);
endmodule

// file: shared/srp_cfg.svh
// constants of the serial radio pin control block
`ifndef SRP_CFG_SVH
`define SRP_CFG_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define SRP_CLK_MHZ 10
`define SRP_TICK_US 1000
`define SRP_TICK_CYC (`SRP_TICK_US * `SRP_CLK_MHZ)
`define SRP_DEB_TICKS 4
`define SRP_RESET_MS 1000
`define SRP_HOST_RST_MS 1100
`define SRP_GAP_MS 100
`define SRP_PAIR_MS 2000
`define SRP_CONNECT_MS 10000
`define SRP_BAUD_DEFAULT 9600
`define SRP_BAUD_DIV ((`SRP_CLK_MHZ * 1000000 + `SRP_BAUD_DEFAULT / 2) / `SRP_BAUD_DEFAULT)
`define SRP_HWFC_DEFAULT 1'b1
`define SRP_CR 8'h0D
`define SRP_LF 8'h0A
// ----------------------------------------
// controller registers
// ----------------------------------------
`define SRP_CTRL_OFS 5'h00
`define SRP_STAT_OFS 5'h04
`define SRP_IRQ_STAT_OFS 5'h08
`define SRP_IRQ_CLR_OFS 5'h0C
`define SRP_IRQ_EN_OFS 5'h10
`define SRP_CTRL_RST_BIT 0
`define SRP_CTRL_PAIR1_BIT 1
`define SRP_CTRL_PAIR2_BIT 2
`define SRP_IRQ_UP_BIT 0
`define SRP_IRQ_DOWN_BIT 1
`define SRP_IRQ_DONE_BIT 2
`define SRP_IRQ_TMO_BIT 3
`define SRP_IRQ_EN_RST 4'h0
`endif

// file: shared/srp_if.sv
// pin bundle between the adapter and its host controller
`timescale 1ns/1ps
interface srp_if;
  logic txd;       // adapter serial out
  logic rxd;       // adapter serial in
  logic rts_n;     // adapter ready to receive, low active
  logic cts_n;     // host allows adapter to send, low active
  logic pair_n;    // pairing input, low active
  logic rst_n;     // reset pin, low active
  logic link_up_n; // link established, low active
  modport dev (output txd, output rts_n, output link_up_n, input rxd, input cts_n, input pair_n, input rst_n);
  modport host (input txd, input rts_n, input link_up_n, output rxd, output cts_n, output pair_n, output rst_n);
endinterface

// file: shared/srp_pkg.sv
// types of the serial radio pin control block
package srp_pkg;
  typedef enum logic [1:0] {cmd_wait_mode, connect_last_mode, wait_last_mode, wait_any_mode} srp_mode_t;
  typedef enum logic [1:0] {srp_standby, srp_pending, srp_connect} srp_status_t;
  typedef enum logic [1:0] {srp_ok, srp_error, srp_connect_msg, srp_disconnect_msg} srp_resp_t;
  typedef enum logic [2:0] {hs_idle, hs_rst, hs_gap, hs_low1, hs_high, hs_low2, hs_wait} srp_hseq_t;
endpackage

// file: verif/srp_asserts.sv
// concurrent checks on the adapter pins and pairing state
`timescale 1ns/1ps
module srp_asserts #(
  parameter int unsigned TICK_CYC = 10
) (
  input wire logic sys_clk, // clock
  input wire logic reset_n, // async reset, low active
  input wire logic txd, // adapter serial out
  input wire logic cts_n, // host lets adapter send
  input wire logic rst_n, // reset pin
  input wire logic link_up_n, // link detect pin
  input wire logic radio_link, // radio core link
  input wire srp_pkg::srp_mode_t mode, // operation mode
  input wire logic master, // master role
  input wire logic pairing, // pairing in progress
  input wire logic [23:0] device_class_value, // class value in use
  input wire logic [23:0] class_pairing, // pairing class value
  input wire logic factory_restore, // restore pulse
  input wire logic resp_busy // response being sent
);
  import srp_pkg::*;
  // ----------------------------------------
  // helper
  // ----------------------------------------
  logic [31:0] low_cnt; // consecutive cycles with the reset pin low
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt <= 32'h0;
    end else begin
      low_cnt <= rst_n ? 32'h0 : low_cnt + 32'h1;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_link_low: assert property (radio_link |=> !link_up_n) else $error("link_up_n high with link");
  a_link_high: assert property (!radio_link |=> link_up_n) else $error("link_up_n low without link");
  a_restore_hold: assert property (factory_restore |-> low_cnt >= TICK_CYC * 1000) else $error("restore early");
  a_restore_mode: assert property (factory_restore |=> mode == cmd_wait_mode && !master)
    else $error("restore left mode");
  a_mode_enter: assert property ($changed(mode) && $past(mode) == cmd_wait_mode |-> mode == wait_any_mode)
    else $error("bad first step");
  a_mode_second: assert property ($changed(mode) && mode == connect_last_mode |-> $past(mode) == wait_any_mode)
    else $error("bad second step");
  a_master_role: assert property ($rose(master) |-> mode == connect_last_mode) else $error("master early");
  a_pair_quiet: assert property ($rose(resp_busy) |-> !$past(pairing)) else $error("response while pairing");
  a_class_swap: assert property (pairing && $past(pairing) |-> device_class_value == class_pairing)
    else $error("class not swapped");
  // the sender reads the clear-to-send input with no register; the check also accepts it one cycle earlier
  a_flow_start: assert property ($fell(txd) |-> !$past(cts_n) || !$past(cts_n, 2))
    else $error("start without cts");
  c_restore: cover property (factory_restore);
  c_master: cover property ($rose(master));
  c_resp: cover property ($rose(resp_busy));
  c_link: cover property ($fell(link_up_n));
endmodule

// file: verif/tb.sv
// bench joining adapter and host ends over the pin bundle
`timescale 1ns/1ps
`include "srp_cfg.svh"
module tb;
  import srp_pkg::*;
  localparam int unsigned TICK = 2; // one ms becomes two cycles
  localparam logic [31:0] A_CTRL = 32'(`SRP_CTRL_OFS), A_STAT = 32'(`SRP_STAT_OFS), A_IST = 32'(`SRP_IRQ_STAT_OFS);
  localparam logic [31:0] A_CLR = 32'(`SRP_IRQ_CLR_OFS), A_EN = 32'(`SRP_IRQ_EN_OFS);
  logic sys_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic hreadyout, hresp, irq, user_rxd, user_rts_n, rx_line, master, pairing, factory_restore, resp_busy;
  logic [31:0] hrdata;
  logic user_txd = 1'b1, hwfc_new = 1'b1;
  logic user_cts_n = 1'b0, radio_link = 1'b0, soft_reset = 1'b0, resp_req = 1'b0, rx_full = 1'b0;
  logic [15:0] baud_div_new = 16'h0010;
  srp_resp_t resp_kind = srp_ok;
  logic [23:0] class_normal = 24'hA5A5A5, class_pairing = 24'hC3C3C3, device_class_value;
  srp_mode_t mode;
  srp_status_t status;
  int miscompares = 0;
  int samples_checked = 0;
  logic [7:0] first_ch [4] = '{8'h4F, 8'h45, 8'h43, 8'h44};
  int txt_len [4] = '{2, 5, 7, 10};
  always #50 sys_clk = ~sys_clk;
  srp_if link();
  srp_dev #(.TICK_CYC(TICK)) u_srp_dev (.sys_clk(sys_clk), .reset_n(reset_n), .pins(link),
    .radio_link(radio_link), .soft_reset(soft_reset), .baud_div_new(baud_div_new), .hwfc_new(hwfc_new),
    .resp_req(resp_req), .resp_kind(resp_kind), .rx_full(rx_full), .class_normal(class_normal),
    .class_pairing(class_pairing), .rx_line(rx_line), .mode(mode), .status(status), .master(master),
    .pairing(pairing), .device_class_value(device_class_value), .factory_restore(factory_restore),
    .resp_busy(resp_busy));
  srp_host #(.TICK_CYC(TICK)) u_srp_host (.sys_clk(sys_clk), .reset_n(reset_n), .pins(link), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq), .user_txd(user_txd),
    .user_cts_n(user_cts_n), .user_rxd(user_rxd), .user_rts_n(user_rts_n));
  srp_asserts #(.TICK_CYC(TICK)) u_srp_asserts (.sys_clk(sys_clk), .reset_n(reset_n), .txd(link.txd),
    .cts_n(link.cts_n), .rst_n(link.rst_n), .link_up_n(link.link_up_n), .radio_link(radio_link), .mode(mode),
    .master(master), .pairing(pairing), .device_class_value(device_class_value), .class_pairing(class_pairing),
    .factory_restore(factory_restore), .resp_busy(resp_busy));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string name);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(name, exp, r);
  endtask
  // polls the event flags; each poll is one two-cycle read
  task automatic wait_irq(input int bitn, output logic [31:0] r);
    int i;
    r = 32'h0;
    for (i = 0; i < 20000 && r[bitn] !== 1'b1; i++) ahb(1'b0, A_IST, 32'h0, r);
  endtask
  // 16 cycles per bit after the soft reset loads the short divisor
  task automatic uart_rx(output logic [7:0] b, output bit got);
    int i;
    got = 1'b0;
    b = 8'h00;
    for (i = 0; i < 400 && link.txd !== 1'b0; i++) @(negedge sys_clk);
    if (link.txd === 1'b0) begin
      got = 1'b1;
      repeat (8) @(negedge sys_clk);
      for (i = 0; i < 8; i++) begin
        repeat (16) @(negedge sys_clk);
        b[i] = link.txd;
      end
      repeat (16) @(negedge sys_clk);
      chk("stop bit", 32'h1, {31'h0, link.txd});
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    int i, k, n;
    bit got;
    logic [7:0] b;
    logic [15:0] tail;
    logic [31:0] r;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    chk("link_up_n idle", 32'h1, {31'h0, link.link_up_n});
    chk("mode reset", 32'(cmd_wait_mode), 32'(mode));
    chk("status reset", 32'(srp_standby), 32'(status));
    chk("pins idle", 32'h3, {30'h0, link.rst_n, link.pair_n});
    rd_chk(A_EN, {28'h0, `SRP_IRQ_EN_RST}, "irq enable reset");
    rd_chk(32'h14, 32'h0, "unmapped read");
    wr(32'h14, 32'hF);
    rd_chk(A_EN, 32'h0, "enable after unmapped write");
    rx_full <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("rts_n full", 32'h1, {31'h0, user_rts_n});
    rx_full <= 1'b0;
    user_txd <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("rts_n ready", 32'h0, {31'h0, user_rts_n});
    chk("rx_line", 32'h0, {31'h0, rx_line});
    user_txd <= 1'b1;
    wr(A_EN, 32'hF);
    radio_link <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("link_up_n on", 32'h0, {31'h0, link.link_up_n});
    chk("status link", 32'(srp_connect), 32'(status));
    chk("irq on", 32'h1, {31'h0, irq});
    rd_chk(A_IST, 32'h1, "link up flag");
    rd_chk(A_STAT, 32'h1, "link status");
    wr(A_EN, 32'h0);
    @(posedge sys_clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(A_EN, 32'hF);
    wr(A_CLR, 32'h1);
    rd_chk(A_IST, 32'h0, "flag cleared");
    chk("irq cleared", 32'h0, {31'h0, irq});
    radio_link <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("link_up_n off", 32'h1, {31'h0, link.link_up_n});
    rd_chk(A_IST, 32'h2, "link down flag");
    wr(A_CLR, 32'hF);
    soft_reset <= 1'b1;
    @(posedge sys_clk);
    soft_reset <= 1'b0;
    for (k = 0; k < 4; k++) begin
      user_cts_n <= (k == 0);
      resp_kind <= srp_resp_t'(k);
      resp_req <= 1'b1;
      @(posedge sys_clk);
      resp_req <= 1'b0;
      if (k == 0) begin
        repeat (100) @(posedge sys_clk);
        chk("txd stalled", 32'h1, {31'h0, link.txd});
        user_cts_n <= 1'b0;
      end
      n = 0;
      got = 1'b1;
      tail = 16'h0;
      while (got && n < 20) begin
        uart_rx(b, got);
        if (got) begin
          if (n < 2) chk("lead byte", (n == 0) ? 32'h0D : 32'h0A, {24'h0, b});
          if (n == 2) chk("first letter", {24'h0, first_ch[k]}, {24'h0, b});
          tail = {tail[7:0], b};
          n++;
        end
      end
      chk("frame bytes", 32'(txt_len[k] + 4), 32'(n));
      chk("trail bytes", 32'h0D0A, {16'h0, tail});
      chk("resp_busy end", 32'h0, {31'h0, resp_busy});
    end
    wr(A_CTRL, 32'h4);
    for (i = 0; i < 20000 && pairing !== 1'b1; i++) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
    chk("mode first low", 32'(wait_any_mode), 32'(mode));
    chk("class swap", {8'h0, class_pairing}, {8'h0, device_class_value});
    resp_req <= 1'b1;
    @(posedge sys_clk);
    resp_req <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("quiet pairing", 32'h0, {31'h0, resp_busy});
    wr(A_CTRL, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk("ctrl ignored busy", 32'h1, {31'h0, link.rst_n});
    for (i = 0; i < 20000 && mode !== connect_last_mode; i++) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
    chk("master role", 32'h1, {31'h0, master});
    radio_link <= 1'b1;
    wait_irq(`SRP_IRQ_DONE_BIT, r);
    chk("done flag", 32'h1, {31'h0, r[`SRP_IRQ_DONE_BIT]});
    chk("pairing ended", 32'h0, {31'h0, pairing});
    radio_link <= 1'b0;
    wr(A_CLR, 32'hF);
    wr(A_CTRL, 32'h2);
    for (i = 0; i < 20000 && pairing !== 1'b1; i++) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
    chk("unit one mode", 32'(wait_any_mode), 32'(mode));
    chk("unit one slave", 32'h0, {31'h0, master});
    wait_irq(`SRP_IRQ_TMO_BIT, r);
    chk("timeout flag", 32'h1, {31'h0, r[`SRP_IRQ_TMO_BIT]});
    rd_chk(A_STAT, 32'h0, "sequencer idle");
    chk("bus okay", 32'h0, {31'h0, hresp});
    test_done;
  end
  initial begin
    repeat (95000) @(posedge sys_clk);
    miscompares++;
    $display("ERROR watchdog expected end seen timeout");
    test_done;
  end
endmodule
